// file: inc/ipr_pkg.sv
// package for the interrupt priority register bank 15..20
package ipr_pkg;
    // register byte addresses on apb
    localparam logic [7:0] IPR_OFF_15 = 8'h00;
    localparam logic [7:0] IPR_OFF_16 = 8'h04;
    localparam logic [7:0] IPR_OFF_17 = 8'h08;
    localparam logic [7:0] IPR_OFF_18 = 8'h0c;
    localparam logic [7:0] IPR_OFF_19 = 8'h10;
    localparam logic [7:0] IPR_OFF_20 = 8'h14;
    localparam int IPR_NUM_FIELDS = 17;
    localparam int IPR_FIELD_W = 3;
    // field lsb positions within a 16-bit register
    localparam int IPR_POS_HI = 12;
    localparam int IPR_POS_MH = 8;
    localparam int IPR_POS_ML = 4;
    localparam int IPR_POS_LO = 0;
    // reset code: top bit set, level four
    localparam logic [2:0] IPR_FIELD_RESET = 3'h4;
    localparam logic [2:0] IPR_CODE_OFF = 3'h0;
    localparam logic [2:0] IPR_CODE_MAX = 3'h7;
    // one-cycle apb answer, no wait states
    localparam int IPR_WAIT_CYCLES = 0;

    typedef struct packed {
        logic [2:0] multi_cc1_priority;
        logic [2:0] calendar_clock_priority;
        logic [2:0] dma_ch5_priority;
        logic [2:0] serial3_receive_priority;
        logic [2:0] crc_error_priority;
        logic [2:0] uart2_error_priority;
        logic [2:0] uart1_error_priority;
        logic [2:0] single_cc2_priority;
        logic [2:0] i2c3_master_priority;
        logic [2:0] i2c3_slave_priority;
        logic [2:0] single_cc7_priority;
        logic [2:0] voltage_detect_priority;
        logic [2:0] dac_priority;
        logic [2:0] charge_time_priority;
        logic [2:0] uart3_transmit_priority;
        logic [2:0] uart3_receive_priority;
        logic [2:0] uart3_error_priority;
    } ipr_levels_t;

    typedef struct packed {
        logic [16:0] enable;
    } ipr_enables_t;
endpackage

// file: rtl/ipr_field.sv
// one 3-bit priority field with its decoded level
`timescale 1ns/10ps
module ipr_field
    import ipr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic [2:0] wr_code,
    output logic [2:0] code,
    output logic [2:0] level,
    output logic enable
);
    logic [2:0] next_level;
    logic next_enable;

    // code maps straight to level: 7 highest, 1 lowest, 0 off
    assign next_level = code;
    assign next_enable = (code != IPR_CODE_OFF);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            code <= IPR_FIELD_RESET;
        end else if (wr_en) begin
            code <= wr_code;
        end
    end

    // registered so the bank outputs come from flip-flops
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            level <= IPR_FIELD_RESET;
            enable <= 1'b1;
        end else begin
            level <= next_level;
            enable <= next_enable;
        end
    end
endmodule // ipr_field

// file: rtl/ipr_bank.sv
// apb register bank holding interrupt priority registers 15..20
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/10ps
module ipr_bank
    import ipr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output ipr_levels_t levels,
    output ipr_enables_t enables
);
    // field index order: fixed by table below
    localparam int NF = IPR_NUM_FIELDS;

    logic sel_15;
    logic sel_16;
    logic sel_17;
    logic sel_18;
    logic sel_19;
    logic sel_20;
    logic hit;
    logic wr_acc;
    logic rd_acc;
    logic setup;
    logic [15:0] wdata16;
    logic [1:0] lane_ok;
    logic [NF-1:0] fld_wr;
    logic [NF*3-1:0] fld_wdata;
    logic [NF*3-1:0] fld_code;
    logic [NF*3-1:0] fld_level;
    logic [NF-1:0] fld_en;
    logic [15:0] rd_15;
    logic [15:0] rd_16;
    logic [15:0] rd_17;
    logic [15:0] rd_18;
    logic [15:0] rd_19;
    logic [15:0] rd_20;
    logic [15:0] rd_mux;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    // address decode
    assign sel_15 = (paddr == IPR_OFF_15);
    assign sel_16 = (paddr == IPR_OFF_16);
    assign sel_17 = (paddr == IPR_OFF_17);
    assign sel_18 = (paddr == IPR_OFF_18);
    assign sel_19 = (paddr == IPR_OFF_19);
    assign sel_20 = (paddr == IPR_OFF_20);
    assign hit = sel_15 | sel_16 | sel_17 | sel_18 | sel_19 | sel_20;
    // setup cycle only: answer comes one edge later in the access phase
    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pready & pwrite & hit;
    assign rd_acc = setup & ~pwrite;
    assign wdata16 = pwdata[15:0];
    assign lane_ok = pstrb[1:0];

    // per-field write strobes; byte lane 1 covers high fields, lane 0 low
    assign fld_wr[0] = wr_acc & sel_15 & lane_ok[1];
    assign fld_wr[1] = wr_acc & sel_15 & lane_ok[1];
    assign fld_wr[2] = wr_acc & sel_15 & lane_ok[0];
    assign fld_wr[3] = wr_acc & sel_15 & lane_ok[0];
    assign fld_wr[4] = wr_acc & sel_16 & lane_ok[1];
    assign fld_wr[5] = wr_acc & sel_16 & lane_ok[1];
    assign fld_wr[6] = wr_acc & sel_16 & lane_ok[0];
    assign fld_wr[7] = wr_acc & sel_16 & lane_ok[0];
    assign fld_wr[8] = wr_acc & sel_17 & lane_ok[1];
    assign fld_wr[9] = wr_acc & sel_17 & lane_ok[1];
    assign fld_wr[10] = wr_acc & sel_18 & lane_ok[0];
    assign fld_wr[11] = wr_acc & sel_18 & lane_ok[0];
    assign fld_wr[12] = wr_acc & sel_19 & lane_ok[1];
    assign fld_wr[13] = wr_acc & sel_19 & lane_ok[0];
    assign fld_wr[14] = wr_acc & sel_20 & lane_ok[1];
    assign fld_wr[15] = wr_acc & sel_20 & lane_ok[1];
    assign fld_wr[16] = wr_acc & sel_20 & lane_ok[0];

    // only field bits are taken from the write data
    assign fld_wdata[2:0] = wdata16[IPR_POS_HI +: IPR_FIELD_W];
    assign fld_wdata[5:3] = wdata16[IPR_POS_MH +: IPR_FIELD_W];
    assign fld_wdata[8:6] = wdata16[IPR_POS_ML +: IPR_FIELD_W];
    assign fld_wdata[11:9] = wdata16[IPR_POS_LO +: IPR_FIELD_W];
    assign fld_wdata[14:12] = wdata16[IPR_POS_HI +: IPR_FIELD_W];
    assign fld_wdata[17:15] = wdata16[IPR_POS_MH +: IPR_FIELD_W];
    assign fld_wdata[20:18] = wdata16[IPR_POS_ML +: IPR_FIELD_W];
    assign fld_wdata[23:21] = wdata16[IPR_POS_LO +: IPR_FIELD_W];
    assign fld_wdata[26:24] = wdata16[IPR_POS_HI +: IPR_FIELD_W];
    assign fld_wdata[29:27] = wdata16[IPR_POS_MH +: IPR_FIELD_W];
    assign fld_wdata[32:30] = wdata16[IPR_POS_ML +: IPR_FIELD_W];
    assign fld_wdata[35:33] = wdata16[IPR_POS_LO +: IPR_FIELD_W];
    assign fld_wdata[38:36] = wdata16[IPR_POS_MH +: IPR_FIELD_W];
    assign fld_wdata[41:39] = wdata16[IPR_POS_ML +: IPR_FIELD_W];
    assign fld_wdata[44:42] = wdata16[IPR_POS_HI +: IPR_FIELD_W];
    assign fld_wdata[47:45] = wdata16[IPR_POS_MH +: IPR_FIELD_W];
    assign fld_wdata[50:48] = wdata16[IPR_POS_ML +: IPR_FIELD_W];

    genvar gi;
    generate
        for (gi = 0; gi < NF; gi++) begin : g_field
            ipr_field u_field (
                .core_clk(core_clk),
                .rst_b(rst_b),
                .wr_en(fld_wr[gi]),
                .wr_code(fld_wdata[gi*3 +: 3]),
                .code(fld_code[gi*3 +: 3]),
                .level(fld_level[gi*3 +: 3]),
                .enable(fld_en[gi])
            );
        end
    endgenerate

    // read images; gaps and nibble top bits are tied low
    assign rd_15 = {1'b0, fld_code[2:0], 1'b0, fld_code[5:3],
                    1'b0, fld_code[8:6], 1'b0, fld_code[11:9]};
    assign rd_16 = {1'b0, fld_code[14:12], 1'b0, fld_code[17:15],
                    1'b0, fld_code[20:18], 1'b0, fld_code[23:21]};
    assign rd_17 = {1'b0, fld_code[26:24], 1'b0, fld_code[29:27], 8'h00};
    assign rd_18 = {9'h000, fld_code[32:30], 1'b0, fld_code[35:33]};
    assign rd_19 = {5'h00, fld_code[38:36], 1'b0, fld_code[41:39], 4'h0};
    assign rd_20 = {1'b0, fld_code[44:42], 1'b0, fld_code[47:45],
                    1'b0, fld_code[50:48], 4'h0};

    assign rd_mux = sel_15 ? rd_15 :
                    sel_16 ? rd_16 :
                    sel_17 ? rd_17 :
                    sel_18 ? rd_18 :
                    sel_19 ? rd_19 :
                    sel_20 ? rd_20 : 16'h0000;

    // upper half of the word always reads zero
    assign next_prdata = rd_acc ? {16'h0000, rd_mux} : 32'h0000_0000;
    // pready pulses once per transfer, in the first access cycle
    assign next_pready = setup;
    assign next_pslverr = setup & ~hit;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // decoded levels and enables toward the arbitration logic
    // field index 0 sits in the struct msbs, so the order is reversed here
    assign levels = ipr_levels_t'({fld_level[2:0],
                                   fld_level[5:3],
                                   fld_level[8:6],
                                   fld_level[11:9],
                                   fld_level[14:12],
                                   fld_level[17:15],
                                   fld_level[20:18],
                                   fld_level[23:21],
                                   fld_level[26:24],
                                   fld_level[29:27],
                                   fld_level[32:30],
                                   fld_level[35:33],
                                   fld_level[38:36],
                                   fld_level[41:39],
                                   fld_level[44:42],
                                   fld_level[47:45],
                                   fld_level[50:48]});
    assign enables.enable = fld_en;
endmodule // ipr_bank

// file: tb/ipr_bank_props.sv
// assertion checker for the priority register bank
`timescale 1ns/10ps
module ipr_bank_props
    import ipr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire ipr_levels_t levels,
    input wire ipr_enables_t enables
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    wire rd_ok = pready && !pwrite;
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held");
    a_upper_half_zero: assert property (rd_ok |-> prdata[31:16] == 16'h0)
        else $error("upper read bits set");
    a_nibble_tops_zero: assert property (rd_ok |-> (prdata[15:0] & 16'h8888) == 16'h0)
        else $error("nibble top bit set");
    a_low_byte_zero: assert property (rd_ok && paddr == IPR_OFF_17 |-> prdata[7:0] == 8'h0)
        else $error("low byte set");
    a_high_bits_zero: assert property (rd_ok && paddr == IPR_OFF_18 |-> prdata[15:7] == 9'h0)
        else $error("upper bits set");
    a_gap_bits_zero: assert property (rd_ok && paddr == IPR_OFF_19 |->
        prdata[15:11] == 5'h0 && prdata[3:0] == 4'h0) else $error("gap bits set");
    a_write_to_level: assert property (pready && pwrite && paddr == IPR_OFF_15 && pstrb[1]
        |-> ##2 levels.multi_cc1_priority == $past(pwdata[14:12], 2)) else $error("level lost");
    a_zero_disables: assert property (enables.enable[0] == (levels.multi_cc1_priority != 3'h0))
        else $error("enable wrong");
    a_unmapped_err: assert property (pready |->
        pslverr == (paddr > IPR_OFF_20 || paddr[1:0] != 2'h0)) else $error("error flag wrong");
endmodule // ipr_bank_props
bind ipr_bank ipr_bank_props u_props (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .levels(levels), .enables(enables));

// file: tb/testbench.sv
// self-checking bench for the priority register bank
`timescale 1ns/10ps
module testbench
    import ipr_pkg::*;
;
    logic core_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr;
    ipr_levels_t levels;
    ipr_enables_t enables;
    int n_errors = 0, n_checks = 0;
    logic [15:0] rst_val [6] = '{16'h4444, 16'h4444, 16'h4400, 16'h0044, 16'h0440, 16'h4440};
    logic [15:0] mask [6] = '{16'h7777, 16'h7777, 16'h7700, 16'h0077, 16'h0770, 16'h7770};
    ipr_bank dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .levels(levels), .enables(enables));
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    // apb master: request held until pready is seen at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check32(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #(20 * 3000);
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            xfer(1'b0, 8'(i * 4), 32'h0, 4'h0);
            check32("reset value", {16'h0, rst_val[i]}, rd);
        end
        xfer(1'b0, 8'h18, 32'h0, 4'h0);
        check32("unmapped read", 32'h0, rd);
        check32("unmapped read err", 32'h1, {31'h0, err});
        check32("reset levels", 32'h1, {31'h0, levels == {17{IPR_FIELD_RESET}}});
        $display("test reset values done");
        // all ones everywhere: only field bits may stick
        for (int i = 0; i < 6; i++) begin
            xfer(1'b1, 8'(i * 4), 32'hffffffff, 4'hf);
            xfer(1'b0, 8'(i * 4), 32'h0, 4'h0);
            check32("ones readback", {16'h0, mask[i]}, rd);
        end
        check32("ones enables", 32'h1ffff, {15'h0, enables});
        check32("ones levels", 32'h7, {29'h0, levels.uart3_error_priority});
        $display("test all ones done");
        // only lane one written, lane zero must keep its sevens
        xfer(1'b1, IPR_OFF_15, 32'h0, 4'h2);
        xfer(1'b0, IPR_OFF_15, 32'h0, 4'h0);
        check32("lane write", 32'h0077, rd);
        check32("lane levels", 32'h07,
            {26'h0, levels.calendar_clock_priority, levels.dma_ch5_priority});
        check32("lane enables", 32'h1fffc, {15'h0, enables});
        xfer(1'b1, 8'h18, 32'hffffffff, 4'hf);
        check32("unmapped write err", 32'h1, {31'h0, err});
        $display("test strobes done");
        for (int c = 1; c < 9; c++) begin
            xfer(1'b1, IPR_OFF_15, {16'h0, {4{1'b0, 3'(c)}}}, 4'hf);
            xfer(1'b0, IPR_OFF_15, 32'h0, 4'h0);
            check32("code readback", 32'(c % 8) * 32'h1111, rd);
            check32("code level", 32'(c % 8), {29'h0, levels.multi_cc1_priority});
            check32("code enable", 32'(c != 8), {31'h0, enables.enable[0]});
        end
        $display("test code walk done");
        // second reset in mid-run
        rst_b <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        xfer(1'b0, IPR_OFF_15, 32'h0, 4'h0);
        check32("rereset value", 32'h4444, rd);
        check32("rereset level", 32'h4, {29'h0, levels.multi_cc1_priority});
        $display("test second reset done");
        end_of_test();
    end
endmodule // testbench
